// >>> dv/cie_exec_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module cie_exec_test
   import cie_pkg::*;
;
   logic                  ref_clk, reset, instr_valid, instr_dest, zero_flag, pc_load, flush, busy, mem_we;
   logic [3:0]            instr_op;
   logic [CIE_ADDR_W-1:0] instr_addr, mem_waddr;
   logic [CIE_JUMP_W-1:0] instr_jump;
   logic [CIE_DATA_W-1:0] instr_lit, page_latch, acc_out, mem_wdata;
   logic [CIE_PC_W-1:0]   pc_in, pc_out;
   int                    n_mismatch, n_checks;

   cie_exec u_dut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_addr(instr_addr), .instr_dest(instr_dest), .instr_jump(instr_jump), .instr_lit(instr_lit),
      .pc_in(pc_in), .page_latch(page_latch), .acc_out(acc_out), .zero_flag(zero_flag), .pc_out(pc_out),
      .pc_load(pc_load), .flush(flush), .busy(busy), .mem_we(mem_we), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata));

   // ============================================================
   // Drivers
   // Offers one instruction and waits out busy; with a follow code the next instruction is
   // offered at once, so it lands in the slot after the accepting edge.
   task issue(input logic [3:0] op, input logic [6:0] a, input logic d, input logic [10:0] k,
              input logic [7:0] lit, input int cyc, input logic [3:0] follow);
      int   n;
      logic b;
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_op    <= op;
      instr_addr  <= a;
      instr_dest  <= d;
      instr_jump  <= k;
      instr_lit   <= lit;
      n = 0;
      do begin
         @(negedge ref_clk);
         b = busy;
         @(posedge ref_clk);
         n++;
      end while (b === 1'b1 && n < 4);
      if (follow !== CIE_OP_NONE) begin
         instr_op <= follow;
      end else begin
         instr_valid <= 1'b0;
      end
      @(negedge ref_clk);
      `CHK("edges", cyc, n)
   endtask : issue

   task release_valid();
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      @(negedge ref_clk);
   endtask : release_valid

   task see(input logic [7:0] a, input logic z, input logic w);
      `CHK("acc_out", a, acc_out)
      `CHK("zero_flag", z, zero_flag)
      `CHK("mem_we", w, mem_we)
   endtask : see

   // ============================================================
   // Scenarios
   task t_acc();
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h5a, 1, CIE_OP_NONE);
      see(8'h5a, 1'b0, 1'b0);
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h81, 1, CIE_OP_NONE);
      see(8'hdb, 1'b0, 1'b0);
      issue(CIE_OP_CLRACC, 0, 0, 0, 8'h00, 1, CIE_OP_NONE);
      see(8'h00, 1'b1, 1'b0);
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h00, 1, CIE_OP_NONE);
      see(8'h00, 1'b1, 1'b0);
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h01, 1, CIE_OP_NONE);
      issue(CIE_OP_CLRREG, 7'h7f, 0, 0, 8'h00, 1, CIE_OP_NONE);
      see(8'h01, 1'b1, 1'b1);
      `CHK("mem_waddr", 7'h7f, mem_waddr)
      `CHK("mem_wdata", 8'h00, mem_wdata)
      $display("test accumulator and clear done");
   endtask : t_acc

   task t_dec();
      issue(CIE_OP_DEC, 7'h7f, 1'b0, 0, 0, 2, CIE_OP_NONE);
      see(8'hff, 1'b0, 1'b0);
      issue(CIE_OP_DEC, 7'h7f, 1'b1, 0, 0, 2, CIE_OP_NONE);
      see(8'hff, 1'b0, 1'b1);
      `CHK("mem_wdata", 8'hff, mem_wdata)
      issue(CIE_OP_INCSKZ, 7'h7f, 1'b1, 0, 0, 2, CIE_OP_CLRACC);
      see(8'hff, 1'b0, 1'b1);
      `CHK("mem_wdata", 8'h00, mem_wdata)
      `CHK("flush", 1'b1, flush)
      release_valid();
      see(8'hff, 1'b0, 1'b0);
      issue(CIE_OP_INCSKZ, 7'h7f, 1'b0, 0, 0, 2, CIE_OP_NONE);
      see(8'h01, 1'b0, 1'b0);
      `CHK("flush", 1'b0, flush)
      issue(CIE_OP_INCSKZ, 7'h7f, 1'b1, 0, 0, 2, CIE_OP_NONE);
      issue(CIE_OP_DEC, 7'h7f, 1'b0, 0, 0, 2, CIE_OP_NONE);
      see(8'h00, 1'b1, 1'b0);
      $display("test decrement and increment skip done");
   endtask : t_dec

   task t_decskz();
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h80, 1, CIE_OP_NONE);
      issue(CIE_OP_DECSKZ, 7'h7f, 1'b1, 0, 0, 2, CIE_OP_CLRACC);
      see(8'h80, 1'b0, 1'b1);
      `CHK("flush", 1'b1, flush)
      release_valid();
      see(8'h80, 1'b0, 1'b0);
      issue(CIE_OP_CLRACC, 0, 0, 0, 0, 1, CIE_OP_NONE);
      issue(CIE_OP_DECSKZ, 7'h7f, 1'b0, 0, 0, 2, CIE_OP_NONE);
      see(8'hff, 1'b1, 1'b0);
      `CHK("flush", 1'b0, flush)
      $display("test decrement skip done");
   endtask : t_decskz

   task t_jump();
      @(posedge ref_clk);
      page_latch <= 8'h5a;
      issue(CIE_OP_JUMP, 0, 0, 11'h7ff, 8'hff, 1, CIE_OP_ORLIT);
      `CHK("pc_load", 1'b1, pc_load)
      `CHK("pc_out", {4'hb, 11'h7ff}, pc_out)
      `CHK("flush", 1'b1, flush)
      release_valid();
      `CHK("pc_load", 1'b0, pc_load)
      `CHK("pc_out", 15'h1234, pc_out)
      see(8'hff, 1'b1, 1'b0);
      @(posedge ref_clk);
      page_latch <= 8'h87;
      issue(CIE_OP_JUMP, 0, 0, 11'h000, 8'h00, 1, CIE_OP_NONE);
      `CHK("pc_out", 15'h0000, pc_out)
      $display("test jump done");
   endtask : t_jump

   task t_reset();
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h3c, 1, CIE_OP_NONE);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      see(8'h00, 1'b0, 1'b0);
      `CHK("pc_load", 1'b0, pc_load)
      `CHK("flush", 1'b0, flush)
      `CHK("pc_out", 15'h0000, pc_out)
      issue(CIE_OP_ORLIT, 0, 0, 0, 8'h24, 1, CIE_OP_NONE);
      see(8'h24, 1'b0, 1'b0);
      $display("test reset done");
   endtask : t_reset

   // ============================================================
   // Run control
   task test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      // The whole sequence needs well under a hundred cycles, so 2000 leaves ample margin.
      #40000;
      n_mismatch++;
      test_done();
   end

   initial begin
      n_mismatch  = 0;
      n_checks    = 0;
      reset       = 1'b1;
      instr_valid = 1'b0;
      instr_op    = CIE_OP_NONE;
      instr_addr  = '0;
      instr_dest  = 1'b0;
      instr_jump  = '0;
      instr_lit   = '0;
      pc_in       = 15'h1234;
      page_latch  = 8'h00;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      t_acc();
      t_dec();
      t_decskz();
      t_jump();
      t_reset();
      test_done();
   end
endmodule : cie_exec_test

// >>> rtl/cie_data_mem.sv
`timescale 1ns/1ps
module cie_data_mem
   import cie_pkg::*;
#(
   parameter int DEPTH = CIE_MAC_DEPTH
) (
   input  wire logic                  ref_clk,
   input  wire logic                  we,
   input  wire logic [CIE_ADDR_W-1:0] waddr,
   input  wire logic [CIE_DATA_W-1:0] wdata,
   input  wire logic [CIE_ADDR_W-1:0] raddr,
   output logic      [CIE_DATA_W-1:0] rdata
);
   if (DEPTH != (1 << CIE_ADDR_W)) begin : g_depth_check
      $error("cie_data_mem depth must match address width");
   end
   logic [CIE_DATA_W-1:0] mem_reg [DEPTH];
   // ============================================================
   // Write first so a read of the word being written returns new data.
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (we && waddr == raddr) begin
         rdata <= wdata;
      end else begin
         rdata <= mem_reg[raddr];
      end
   end
endmodule : cie_data_mem

// >>> rtl/cie_exec.sv
`timescale 1ns/1ps
// How it works
// [RQ1] Clear register writes zero to the addressed register and sets zero flag.
// [RQ2] Clear accumulator needs no operand, zeroes accumulator and sets zero flag.
// [RQ3] Decrement writes register minus one to accumulator or register; zero flag follows.
// [RQ4] Decrement-skip writes register minus one to chosen destination; flags untouched.
// [RQ5] Decrement-skip with zero result turns next instruction into a no-operation.
// [RQ6] Increment-skip writes register plus one to chosen destination; flags untouched.
// [RQ7] Increment-skip with zero result discards next instruction for a no-operation.
// [RQ8] Jump loads its 11-bit operand into program counter bits 10 to 0.
// [RQ9] Jump loads program counter bits 14 to 11 from page latch bits 6 to 3.
// [RQ10] Jump takes two instruction cycles.
// [RQ11] OR-literal ORs accumulator with 8-bit literal, writes accumulator, updates zero flag.
// [RQ12] Register instructions carry a 7-bit address and one destination bit.
// [RQ13] Instructions without skip or jump complete in one cycle; here Decrement takes two cycles for its register read.
module cie_exec
   import cie_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic                  instr_valid,
   input  wire logic [3:0]            instr_op,
   input  wire logic [CIE_ADDR_W-1:0] instr_addr,
   input  wire logic                  instr_dest,
   input  wire logic [CIE_JUMP_W-1:0] instr_jump,
   input  wire logic [CIE_DATA_W-1:0] instr_lit,
   input  wire logic [CIE_PC_W-1:0]   pc_in,
   input  wire logic [CIE_DATA_W-1:0] page_latch,
   output logic      [CIE_DATA_W-1:0] acc_out,
   output logic                       zero_flag,
   output logic      [CIE_PC_W-1:0]   pc_out,
   output logic                       pc_load,
   output logic                       flush,
   output logic                       busy,
   output logic                       mem_we,
   output logic      [CIE_ADDR_W-1:0] mem_waddr,
   output logic      [CIE_DATA_W-1:0] mem_wdata
);
   // ============================================================
   // Operand fetch
   // The register operand is read from a registered memory, so an access
   // spends one cycle reading; the instruction is held during that cycle.
   logic [CIE_DATA_W-1:0] rd_data;
   logic                  mem_we_reg;
   logic [CIE_ADDR_W-1:0] waddr_reg;
   logic [CIE_DATA_W-1:0] wdata_reg;
   cie_state_e            state_reg;
   logic                  phase_reg;
   cie_data_mem #(.DEPTH(CIE_MAC_DEPTH)) u_mem (
      .ref_clk (ref_clk),
      .we      (mem_we_reg),
      .waddr   (waddr_reg),
      .wdata   (wdata_reg),
      .raddr   (instr_addr),     // [RQ12]
      .rdata   (rd_data)
   );
   logic needs_reg;
   assign needs_reg = (instr_op == CIE_OP_DEC) || (instr_op == CIE_OP_DECSKZ) || (instr_op == CIE_OP_INCSKZ);
   logic go;
   assign go = instr_valid && (state_reg == CIE_RUN) && (!needs_reg || phase_reg);
   // ============================================================
   // Arithmetic
   logic [CIE_DATA_W-1:0] dec_val;
   logic [CIE_DATA_W-1:0] inc_val;
   logic [CIE_DATA_W-1:0] or_val;
   assign dec_val = rd_data - CIE_ONE;    // [RQ3] [RQ4]
   assign inc_val = rd_data + CIE_ONE;    // [RQ6]
   assign or_val  = acc_out | instr_lit;  // [RQ11]
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase_reg <= 1'b0;
      end else if (instr_valid && needs_reg && state_reg == CIE_RUN) begin
         phase_reg <= !phase_reg;
      end else begin
         phase_reg <= 1'b0;
      end
   end
   // Busy is decoded from the offered instruction itself, because a registered copy
   // would rise one cycle too late to make the fetch side hold a read-modify operation.
   assign busy = instr_valid && needs_reg && !phase_reg && state_reg == CIE_RUN;
   // ============================================================
   // Accumulator and zero flag
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc_out   <= CIE_ACC_RST;
         zero_flag <= 1'b0;
      end else if (go) begin
         case (instr_op)
            CIE_OP_CLRREG: begin
               zero_flag <= 1'b1;                                  // [RQ1]
            end
            CIE_OP_CLRACC: begin
               acc_out   <= CIE_ZERO;                              // [RQ2]
               zero_flag <= 1'b1;                                  // [RQ2]
            end
            CIE_OP_DEC: begin
               if (instr_dest == CIE_DEST_ACC) acc_out <= dec_val; // [RQ3]
               zero_flag <= (dec_val == CIE_ZERO);                 // [RQ3]
            end
            CIE_OP_DECSKZ: begin
               if (instr_dest == CIE_DEST_ACC) acc_out <= dec_val; // [RQ4]
            end
            CIE_OP_INCSKZ: begin
               if (instr_dest == CIE_DEST_ACC) acc_out <= inc_val; // [RQ6]
            end
            CIE_OP_ORLIT: begin
               acc_out   <= or_val;                                // [RQ11]
               zero_flag <= (or_val == CIE_ZERO);                  // [RQ11]
            end
            default: begin
            end
         endcase
      end
   end
   // ============================================================
   // Register write-back
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mem_we_reg <= 1'b0;
         waddr_reg  <= '0;
         wdata_reg  <= CIE_ZERO;
      end else begin
         mem_we_reg <= 1'b0;
         waddr_reg  <= instr_addr;                                 // [RQ12]
         if (go) begin
            case (instr_op)
               CIE_OP_CLRREG: begin
                  mem_we_reg <= 1'b1;                              // [RQ1]
                  wdata_reg  <= CIE_ZERO;
               end
               CIE_OP_DEC, CIE_OP_DECSKZ: begin
                  mem_we_reg <= (instr_dest != CIE_DEST_ACC);      // [RQ3] [RQ4]
                  wdata_reg  <= dec_val;
               end
               CIE_OP_INCSKZ: begin
                  mem_we_reg <= (instr_dest != CIE_DEST_ACC);      // [RQ6]
                  wdata_reg  <= inc_val;
               end
               default: begin
               end
            endcase
         end
      end
   end
   assign mem_we    = mem_we_reg;
   assign mem_waddr = waddr_reg;
   assign mem_wdata = wdata_reg;
   // ============================================================
   // Skip, jump and flush
   // A flushed slot is one no-operation cycle; any instruction offered then is dropped.
   logic skip_now;
   assign skip_now = go && (((instr_op == CIE_OP_DECSKZ) && (dec_val == CIE_ZERO)) ||
                            ((instr_op == CIE_OP_INCSKZ) && (inc_val == CIE_ZERO)));  // [RQ5] [RQ7]
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= CIE_RUN;
         flush     <= 1'b0;
      end else begin
         case (state_reg)
            CIE_RUN: begin
               if (skip_now || (go && instr_op == CIE_OP_JUMP)) begin
                  state_reg <= CIE_FLUSH;                          // [RQ5] [RQ7] [RQ10]
                  flush     <= 1'b1;
               end else begin
                  flush     <= 1'b0;                               // [RQ13]
               end
            end
            CIE_FLUSH: begin
               state_reg <= CIE_RUN;
               flush     <= 1'b0;
            end
            default: begin
               state_reg <= CIE_RUN;
               flush     <= 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc_out  <= CIE_PC_RST;
         pc_load <= 1'b0;
      end else if (go && instr_op == CIE_OP_JUMP) begin
         pc_out  <= {page_latch[CIE_PAGE_HI:CIE_PAGE_LO], instr_jump};  // [RQ8] [RQ9]
         pc_load <= 1'b1;
      end else begin
         pc_out  <= pc_in;
         pc_load <= 1'b0;
      end
   end
   // ============================================================
   // Checks
   jump_pc_value_a: assert property (@(posedge ref_clk) disable iff (reset)   // [RQ8]
      (go && instr_op == CIE_OP_JUMP) |=> pc_load && pc_out[10:0] == $past(instr_jump))
      else $error("jump low bits wrong");
   jump_page_bits_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ9]
      (go && instr_op == CIE_OP_JUMP) |=> pc_out[14:11] == $past(page_latch[6:3]))
      else $error("jump page bits wrong");
   jump_two_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ10]
      (go && instr_op == CIE_OP_JUMP) |=> flush ##1 !flush)
      else $error("jump not two cycles");
   clear_sets_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // [RQ1]
      (go && instr_op == CIE_OP_CLRREG) |=> zero_flag && mem_we && mem_wdata == 8'h00)
      else $error("clear register wrong");
   clear_acc_zero_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ2]
      (go && instr_op == CIE_OP_CLRACC) |=> zero_flag && acc_out == 8'h00)
      else $error("clear accumulator wrong");
   dec_zero_flag_a: assert property (@(posedge ref_clk) disable iff (reset)   // [RQ3]
      (go && instr_op == CIE_OP_DEC) |=> zero_flag == ($past(rd_data) == 8'h01))
      else $error("decrement zero flag wrong");
   skip_keeps_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // [RQ4]
      (go && (instr_op == CIE_OP_DECSKZ || instr_op == CIE_OP_INCSKZ)) |=> $stable(zero_flag))
      else $error("skip changed zero flag");
   dec_skip_flush_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ5]
      (go && instr_op == CIE_OP_DECSKZ) |=> flush == ($past(rd_data) == 8'h01))
      else $error("decrement skip wrong");
   inc_skip_flush_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ7]
      (go && instr_op == CIE_OP_INCSKZ) |=> flush == ($past(rd_data) == 8'hff))
      else $error("increment skip wrong");
   or_literal_acc_a: assert property (@(posedge ref_clk) disable iff (reset)  // [RQ11]
      (go && instr_op == CIE_OP_ORLIT) |=> acc_out == ($past(acc_out) | $past(instr_lit)))
      else $error("or literal wrong");
endmodule : cie_exec

// >>> rtl/cie_pkg.sv
package cie_pkg;
   // ============================================================
   // Widths
   localparam int CIE_DATA_W  = 8;
   localparam int CIE_ADDR_W  = 7;
   localparam int CIE_JUMP_W  = 11;
   localparam int CIE_PC_W    = 15;
   localparam int CIE_PAGE_LO = 3;
   localparam int CIE_PAGE_HI = 6;
   // ============================================================
   // Operation select codes, chosen for this block
   localparam logic [3:0] CIE_OP_NONE   = 4'h0;
   localparam logic [3:0] CIE_OP_CLRREG = 4'h1;
   localparam logic [3:0] CIE_OP_CLRACC = 4'h2;
   localparam logic [3:0] CIE_OP_DEC    = 4'h3;
   localparam logic [3:0] CIE_OP_DECSKZ = 4'h4;
   localparam logic [3:0] CIE_OP_INCSKZ = 4'h5;
   localparam logic [3:0] CIE_OP_JUMP   = 4'h6;
   localparam logic [3:0] CIE_OP_ORLIT  = 4'h7;
   // ============================================================
   // Reset values
   localparam logic [7:0]  CIE_ACC_RST  = 8'h00;
   localparam logic [14:0] CIE_PC_RST   = 15'h0000;
   localparam logic [7:0]  CIE_ZERO     = 8'h00;
   localparam logic [7:0]  CIE_ONE      = 8'h01;
   localparam logic        CIE_DEST_ACC = 1'b0;
   // ============================================================
   // Cycle counts
   localparam int CIE_SKIP_CYCLES = 2;
   localparam int CIE_JUMP_CYCLES = 2;
   localparam int CIE_MAC_DEPTH   = 128;
   typedef enum logic [1:0] {CIE_RUN, CIE_FLUSH} cie_state_e;
endpackage : cie_pkg
